// >>> logic/rwsc_pkg.sv
// package: constants and types for the reset, wake and strap control block
package rwsc_pkg;
    localparam int REF_CLOCK_MHZ = 25;
    localparam int CLOCK_MHZ = 50;
    localparam logic [1:0] PWR_AWAKE = 2'h0;
    localparam logic [1:0] PWR_SLEEP = 2'h1;
    localparam logic WAKE_POL_RESET = 1'b1;
    localparam logic WAKE_OD_RESET = 1'b0;
    localparam logic WAKE_EN_RESET = 1'b0;
    localparam logic SPEED_STRAP_RESET = 1'b1;
    localparam logic XOVER_STRAP_RESET = 1'b0;

    typedef enum logic [1:0] {
        RWSC_AWAKE_LOCKED = 2'b00,
        RWSC_AWAKE_OPEN = 2'b01,
        RWSC_SLEEP = 2'b11
    } rwsc_mode_t;
endpackage

// >>> logic/rwsc_strap_latch.sv
// strap latch: captures the speed strap once after reset release
`timescale 1ns/1ns
module rwsc_strap_latch
    import rwsc_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic speed_strap,
    output logic speed_latched,
    output logic latched_done
);
    typedef struct packed {
        logic done;
        logic speed;
    } rwsc_latch_t;

    rwsc_latch_t s_q;
    rwsc_latch_t s_d;

    // capture at first edge after release, reset value is a constant
    always_comb begin
        s_d = s_q;
        if (!s_q.done) begin
            s_d.speed = speed_strap;
            s_d.done = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_q <= '{done: 1'b0, speed: SPEED_STRAP_RESET};
        end else begin
            s_q <= s_d;
        end
    end

    assign speed_latched = s_q.speed;
    assign latched_done = s_q.done;

    chk_latch_once: assert property (@(posedge clock) disable iff (!nrst)
        s_q.done |=> $stable(s_q.speed)) else $error("strap changed after latch");
endmodule

// >>> logic/rwsc_top.sv
// top: reset, wake indicator, sleep exit and strap control
`timescale 1ns/1ns
module rwsc_top
    import rwsc_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic host_select_low,
    input wire logic host_write_strobe_low,
    input wire logic host_read_strobe_low,
    input wire logic sleep_request,
    input wire logic wake_event,
    input wire logic wake_enable,
    input wire logic wake_polarity_high,
    input wire logic wake_open_drain,
    input wire logic wake_clear,
    input wire logic crossover_auto_strap,
    input wire logic speed_strap,
    output logic wake_indicator_out,
    output logic wake_indicator_oe,
    output logic host_write_accept,
    output logic asleep,
    output logic crossover_auto_en,
    output logic default_speed_100,
    output logic default_full_duplex
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        rwsc_mode_t mode;
        logic pending;
        logic wr_prev;
        logic accept;
        logic slp;
        logic pin_out;
        logic pin_oe;
        logic xover;
        logic spd;
        logic dup;
    } rwsc_state_t;

    rwsc_state_t s_q;
    rwsc_state_t s_d;
    logic speed_latched;
    logic latched_done;
    logic wr_now;
    logic rd_now;
    logic level;

    rwsc_strap_latch u_latch (
        .clock(clock),
        .nrst(nrst),
        .speed_strap(speed_strap),
        .speed_latched(speed_latched),
        .latched_done(latched_done)
    );

    // ----------------------------------------
    // host cycles
    // ----------------------------------------
    // select and strobe decode, shared by reads and writes
    function automatic logic rwsc_cycle_on(input logic select_low, input logic strobe_low);
        return !select_low && !strobe_low;
    endfunction

    assign wr_now = rwsc_cycle_on(host_select_low, host_write_strobe_low);
    assign rd_now = rwsc_cycle_on(host_select_low, host_read_strobe_low);

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        s_d = s_q;
        level = 1'b0;
        // edge on the write so a held strobe gives one accept
        s_d.wr_prev = wr_now;
        s_d.accept = 1'b0;
        unique case (s_q.mode)
            RWSC_AWAKE_LOCKED: begin
                if (rd_now) begin
                    s_d.mode = RWSC_AWAKE_OPEN;
                end
            end
            RWSC_AWAKE_OPEN: begin
                if (wr_now && !s_q.wr_prev) begin
                    s_d.accept = 1'b1;
                end
                if (sleep_request) begin
                    s_d.mode = RWSC_SLEEP;
                end
            end
            RWSC_SLEEP: begin
                // any write wakes, data ignored; a read is still needed after
                if (wr_now) begin
                    s_d.mode = RWSC_AWAKE_LOCKED;
                    s_d.pending = 1'b0;
                end
            end
            default: begin
                s_d.mode = RWSC_AWAKE_LOCKED;
            end
        endcase
        // own flop so the asleep output never glitches on a mode change
        s_d.slp = (s_d.mode == RWSC_SLEEP);

        // ----------------------------------------
        // wake indicator
        // ----------------------------------------
        // set beats clear
        if (wake_enable && wake_event) begin
            s_d.pending = 1'b1;
        end else if (wake_clear || !wake_enable) begin
            s_d.pending = 1'b0;
        end
        level = s_d.pending;
        // open-drain only pulls to the active level when asserted
        s_d.pin_out = wake_polarity_high ? level : !level;
        s_d.pin_oe = wake_open_drain ? level : 1'b1;

        // ----------------------------------------
        // straps
        // ----------------------------------------
        // crossover follows the strap level; a floating strap reads low through its pull-down
        s_d.xover = crossover_auto_strap;
        s_d.spd = speed_latched;
        s_d.dup = speed_latched;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_q <= '{mode: RWSC_AWAKE_LOCKED,
                     pending: 1'b0,
                     wr_prev: 1'b0,
                     accept: 1'b0,
                     slp: 1'b0,
                     pin_out: !WAKE_POL_RESET,
                     pin_oe: !WAKE_OD_RESET,
                     xover: XOVER_STRAP_RESET,
                     spd: SPEED_STRAP_RESET,
                     dup: SPEED_STRAP_RESET};
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign wake_indicator_out = s_q.pin_out;
    assign wake_indicator_oe = s_q.pin_oe;
    assign host_write_accept = s_q.accept;
    assign asleep = s_q.slp;
    assign crossover_auto_en = s_q.xover;
    assign default_speed_100 = s_q.spd;
    assign default_full_duplex = s_q.dup;

    // ----------------------------------------
    // host cycle checks
    // ----------------------------------------
    chk_no_write_locked: assert property (@(posedge clock) disable iff (!nrst)
        (s_q.mode != RWSC_AWAKE_OPEN) |=> !s_q.accept) else $error("write accepted before read");
    chk_read_unlocks: assert property (@(posedge clock) disable iff (!nrst)
        (s_q.mode == RWSC_AWAKE_LOCKED && rd_now) |=> s_q.mode == RWSC_AWAKE_OPEN) else $error("read did not unlock");
    chk_locked_hold: assert property (@(posedge clock) disable iff (!nrst)
        (s_q.mode == RWSC_AWAKE_LOCKED && !rd_now) |=> s_q.mode == RWSC_AWAKE_LOCKED)
        else $error("unlocked without read");
    chk_accept_pulse: assert property (@(posedge clock) disable iff (!nrst)
        s_q.accept |=> !s_q.accept) else $error("accept longer than one cycle");
    chk_accept_cause: assert property (@(posedge clock) disable iff (!nrst)
        s_q.accept |-> $past(s_q.mode == RWSC_AWAKE_OPEN && wr_now)) else $error("accept without write");

    // ----------------------------------------
    // power mode checks
    // ----------------------------------------
    chk_sleep_wake: assert property (@(posedge clock) disable iff (!nrst)
        (s_q.mode == RWSC_SLEEP && wr_now) |=> s_q.mode == RWSC_AWAKE_LOCKED) else $error("write did not wake");
    chk_stay_asleep: assert property (@(posedge clock) disable iff (!nrst)
        (s_q.mode == RWSC_SLEEP && !wr_now) |=> s_q.mode == RWSC_SLEEP) else $error("left sleep without write");
    chk_sleep_entry: assert property (@(posedge clock) disable iff (!nrst)
        (s_q.mode == RWSC_AWAKE_OPEN && sleep_request) |=> asleep) else $error("sleep request lost");
    chk_open_hold: assert property (@(posedge clock) disable iff (!nrst)
        (s_q.mode == RWSC_AWAKE_OPEN && !sleep_request) |=> s_q.mode == RWSC_AWAKE_OPEN) else $error("left open");
    chk_no_sleep_locked: assert property (@(posedge clock) disable iff (!nrst)
        (s_q.mode == RWSC_AWAKE_LOCKED) |=> !asleep) else $error("slept while locked");
    chk_wake_clears: assert property (@(posedge clock) disable iff (!nrst)
        (s_q.mode == RWSC_SLEEP && wr_now && !wake_event) |=> !s_q.pending) else $error("wake write kept indicator");

    // ----------------------------------------
    // indicator checks
    // ----------------------------------------
    chk_wake_sets: assert property (@(posedge clock) disable iff (!nrst)
        (wake_enable && wake_event) |=> s_q.pending) else $error("wake event lost");
    chk_enable_off: assert property (@(posedge clock) disable iff (!nrst)
        !wake_enable |=> !s_q.pending) else $error("indicator set while disabled");
    chk_clear_drops: assert property (@(posedge clock) disable iff (!nrst)
        (wake_clear && !wake_event) |=> !s_q.pending) else $error("clear ignored");
    chk_pin_level: assert property (@(posedge clock) disable iff (!nrst)
        $past(wake_polarity_high) |-> (s_q.pin_out == s_q.pending)) else $error("indicator polarity wrong");
    chk_pin_inverted: assert property (@(posedge clock) disable iff (!nrst)
        (latched_done && !$past(wake_polarity_high)) |-> (s_q.pin_out == !s_q.pending)) else $error("low polarity wrong");
    chk_open_drain: assert property (@(posedge clock) disable iff (!nrst)
        ($past(wake_open_drain) && !s_q.pending) |-> !s_q.pin_oe) else $error("open drain driven idle");
    chk_push_pull_oe: assert property (@(posedge clock) disable iff (!nrst)
        (latched_done && !$past(wake_open_drain)) |-> s_q.pin_oe) else $error("push-pull not driven");
    chk_od_active: assert property (@(posedge clock) disable iff (!nrst)
        (latched_done && $past(wake_open_drain) && s_q.pending) |-> s_q.pin_oe) else $error("od pin not driven");

    // ----------------------------------------
    // strap checks
    // ----------------------------------------
    chk_crossover: assert property (@(posedge clock) disable iff (!nrst)
        1'b1 |=> crossover_auto_en == $past(crossover_auto_strap)) else $error("crossover strap wrong");
    chk_speed_use: assert property (@(posedge clock) disable iff (!nrst)
        latched_done |=> default_speed_100 == $past(speed_latched)) else $error("speed default wrong");
    chk_duplex_use: assert property (@(posedge clock) disable iff (!nrst)
        latched_done |=> default_full_duplex == $past(speed_latched)) else $error("duplex default wrong");
endmodule

// >>> verif/rwsc_host_model.sv
// host model: one bus cycle at a time on select and strobes
`timescale 1ns/1ns
module rwsc_host_model (
    input wire logic clock,
    output logic host_select_low,
    output logic host_write_strobe_low,
    output logic host_read_strobe_low
);
    initial begin
        host_select_low = 1'b1;
        host_write_strobe_low = 1'b1;
        host_read_strobe_low = 1'b1;
    end
    // wake writes are meant for the byte-order test register; no address pins here
    task automatic cyc(input logic wr);
        @(posedge clock) #2;
        host_select_low = 1'b0;
        host_write_strobe_low = !wr;
        host_read_strobe_low = wr;
        @(posedge clock) #2;
        host_select_low = 1'b1;
        host_write_strobe_low = 1'b1;
        host_read_strobe_low = 1'b1;
    endtask
endmodule

// >>> verif/reset_wake_strap_control_tb.sv
// bench: reset, straps, host unlock, sleep and wake indicator
`timescale 1ns/1ns
module reset_wake_strap_control_tb;
    import rwsc_pkg::*;
    logic clock = 0, nrst = 0, slp = 0, ev = 0, en = 0, pol = 1, od = 0, clr = 0, xs = 0, ss = 0, seen;
    wire logic cs_n, wr_n, rd_n, out, oe, acc, asleep, xen, s100, fdx;
    int n_errors = 0, n_tests = 0, n_acc = 0;
    logic [5:0] rows [8] = '{6'h37, 6'h11, 6'h25, 6'h03, 6'h2D, 6'h08, 6'h18, 6'h1F};
    always #10 clock = !clock;
    rwsc_host_model host (.clock(clock), .host_select_low(cs_n), .host_write_strobe_low(wr_n),
        .host_read_strobe_low(rd_n));
    rwsc_top uut (.clock(clock), .nrst(nrst), .host_select_low(cs_n), .host_write_strobe_low(wr_n),
        .host_read_strobe_low(rd_n), .sleep_request(slp), .wake_event(ev), .wake_enable(en),
        .wake_polarity_high(pol), .wake_open_drain(od), .wake_clear(clr), .crossover_auto_strap(xs),
        .speed_strap(ss), .wake_indicator_out(out), .wake_indicator_oe(oe), .host_write_accept(acc),
        .asleep(asleep), .crossover_auto_en(xen), .default_speed_100(s100), .default_full_duplex(fdx));
    task automatic chk(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock) #2;
    endtask
    // accept may already stand when the cycle task returns, so look from there on
    task automatic watch();
        seen = 0;
        n_acc = 0;
        repeat (4) begin
            seen = seen | (acc === 1'b1);
            if (acc === 1'b1) n_acc++;
            tick(1);
        end
    endtask
    task automatic end_sim();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        tick(5);
        chk("oe_rst", 1'b1, oe);
        chk("out_rst", 1'b0, out);
        chk("s100_rst", 1'b1, s100);
        nrst = 1;
        tick(3);
        ss = 1;
        tick(2);
        chk("s100", 1'b0, s100);
        chk("fdx", 1'b0, fdx);
        $display("test reset and straps done");
        host.cyc(1);
        watch();
        chk("acc_locked", 1'b0, seen);
        host.cyc(0);
        host.cyc(1);
        watch();
        chk("acc_open", 1'b1, seen);
        chk("acc_pulse", 1'b1, n_acc == 1);
        en = 1;
        slp = 1;
        tick(1);
        slp = 0;
        ev = 1;
        tick(1);
        ev = 0;
        tick(1);
        chk("asleep", 1'b1, asleep);
        chk("ind_on", 1'b1, out);
        host.cyc(1);
        tick(1);
        chk("awake", 1'b0, asleep);
        chk("ind_off", 1'b0, out);
        host.cyc(1);
        watch();
        chk("acc_relock", 1'b0, seen);
        $display("test sleep and wake done");
        foreach (rows[i]) begin
            {xs, pol, od} = rows[i][5:3];
            ev = rows[i][2];
            clr = !rows[i][2];
            tick(1);
            {ev, clr} = 2'h0;
            tick(2);
            chk("xen", rows[i][5], xen);
            chk("oe", rows[i][0], oe);
            if (rows[i][0]) chk("out", rows[i][1], out);
        end
        $display("test indicator table done");
        {pol, od} = 2'h2;
        {ev, clr} = 2'h3;
        tick(1);
        {ev, clr} = 2'h0;
        tick(1);
        chk("set_wins", 1'b1, out);
        en = 0;
        ev = 1;
        tick(1);
        chk("en_off", 1'b0, out);
        ev = 0;
        $display("test indicator corners done");
        host.cyc(0);
        ss = 0;
        nrst = 0;
        tick(1);
        chk("s100_rst2", 1'b1, s100);
        chk("asleep_rst", 1'b0, asleep);
        nrst = 1;
        tick(2);
        chk("s100_relatch", 1'b0, s100);
        host.cyc(1);
        watch();
        chk("acc_rst_lock", 1'b0, seen);
        $display("test mid-run reset done");
        end_sim();
    end
endmodule
